// File: src/ata_dma_strobe_timing.sv
// Host strobe, acknowledge and chip-select timing for multiword and Ultra DMA.
// Contract
// - MDMA strobe active count; cycle adds negated.
// - Read strobe negated read-recovery cycles between.
// - Write strobe negated write-recovery cycles between.
// - Acknowledge leads first strobe by setup count.
// - Acknowledge holds negated plus end-cycle count.
// - Chip selects lead and trail like acknowledge in MDMA; Ultra never drives them.
// - Data-in turnaround wait is 2+count+1 cycles.
// - Minimum interlock waits turnaround plus CRC-setup.
// - CRC valid data-setup cycles before acknowledge negates.
// - CRC held ack-timing cycles after acknowledge negates.
// - Acknowledge to first strobe spans envelope count.
// - Lines stable ack-timing cycles around acknowledge.
// - Drivers released at turnaround with zero delay.
`timescale 1ns/1ps
module ata_dma_strobe_timing (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Transfer control.
	input wire logic start,
	input wire logic ultra_mode,
	input wire logic write_dir,
	input wire logic [7:0] word_count,
	input wire logic stop,
	// Timing settings.
	input wire dma_timing_pkg::multiword_timing_setting_t multiword_timing_setting,
	input wire dma_timing_pkg::ultra_timing_setting_t ultra_timing_setting,
	// Drive side.
	input wire logic dma_request,
	input wire logic device_bus_released,
	// Pins and status.
	output dma_timing_pkg::ata_pins_t pins,
	output logic busy
);

	typedef struct packed {
		dma_timing_pkg::state_t st;
		logic [dma_timing_pkg::CW-1:0] cnt;
		logic [7:0] words;
		logic wr;
		logic [1:0] req_sync;
		logic [1:0] rel_sync;
		dma_timing_pkg::ata_pins_t pins;
	} state_reg_t;

	state_reg_t q;
	state_reg_t d;

	// Loads a count, never below one cycle.
	function automatic logic [dma_timing_pkg::CW-1:0] ld(input logic [dma_timing_pkg::CW-1:0] v);
		ld = (v == dma_timing_pkg::ZERO) ? dma_timing_pkg::ONE : v;
	endfunction

	wire logic expired = (q.cnt == dma_timing_pkg::ONE);
	wire logic req_s = q.req_sync[1];
	wire logic rel_s = q.rel_sync[1];

	always_comb begin
		d = q;
		d.req_sync = {q.req_sync[0], dma_request};
		d.rel_sync = {q.rel_sync[0], device_bus_released};
		if (q.cnt != dma_timing_pkg::ZERO) begin
			d.cnt = q.cnt - dma_timing_pkg::ONE;
		end
		unique case (q.st)
			dma_timing_pkg::S_IDLE: begin
				if (start && req_s) begin
					d.wr = write_dir;
					d.words = word_count;
					if (ultra_mode) begin
						// Lines stay quiet a full ack-timing span before acknowledge rises.
						d.st = dma_timing_pkg::S_U_PRE;
						d.cnt = ld(ultra_timing_setting.ack_timing_cycles);
					end else begin
						d.pins.dma_acknowledge = 1'b1;
						d.st = dma_timing_pkg::S_M_SETUP;
						d.pins.drive_chip_selects = 1'b1;
						d.cnt = ld(multiword_timing_setting.ack_setup_cycles);
					end
				end
			end
			dma_timing_pkg::S_M_SETUP, dma_timing_pkg::S_M_RECOVER: begin
				if (expired) begin
					d.st = dma_timing_pkg::S_M_ACTIVE;
					d.pins.read_strobe = ~q.wr;
					d.pins.write_strobe = q.wr;
					d.cnt = ld(multiword_timing_setting.strobe_active_cycles);
				end
			end
			dma_timing_pkg::S_M_ACTIVE: begin
				if (expired) begin
					d.pins.read_strobe = 1'b0;
					d.pins.write_strobe = 1'b0;
					d.words = q.words - dma_timing_pkg::ONE;
					if (q.words <= dma_timing_pkg::ONE || stop || !req_s) begin
						d.st = dma_timing_pkg::S_M_END;
						d.cnt = ld(multiword_timing_setting.strobe_negated_cycles
							+ multiword_timing_setting.mdma_end_cycle_extra);
					end else begin
						d.st = dma_timing_pkg::S_M_RECOVER;
						d.cnt = q.wr ? ld(multiword_timing_setting.write_recovery_cycles)
							: ld(multiword_timing_setting.read_recovery_cycles);
					end
				end
			end
			dma_timing_pkg::S_M_END: begin
				if (expired) begin
					d.st = dma_timing_pkg::S_IDLE;
					d.pins.dma_acknowledge = 1'b0;
					d.pins.drive_chip_selects = 1'b0;
				end
			end
			dma_timing_pkg::S_U_PRE: begin
				if (expired) begin
					d.st = dma_timing_pkg::S_U_ENV;
					d.pins.dma_acknowledge = 1'b1;
					d.pins.host_drive = 1'b0;
					d.cnt = ld(ultra_timing_setting.envelope_cycles);
				end
			end
			dma_timing_pkg::S_U_ENV: begin
				if (expired) begin
					d.st = dma_timing_pkg::S_U_BURST;
					d.pins.read_strobe = 1'b0;
					d.pins.write_strobe = 1'b1;
				end
			end
			dma_timing_pkg::S_U_BURST: begin
				if (stop || !req_s) begin
					d.st = dma_timing_pkg::S_U_TURN;
					d.cnt = ld(dma_timing_pkg::TURN_FIXED + ultra_timing_setting.turnaround_cycles
						+ dma_timing_pkg::TURN_EXTRA);
				end
			end
			dma_timing_pkg::S_U_TURN: begin
				// The wait only runs while the drive has let go; zero release delay.
				if (!rel_s) begin
					d.cnt = q.cnt;
				end else if (expired) begin
					d.st = dma_timing_pkg::S_U_MLI;
					d.pins.host_drive = 1'b1;
					d.cnt = ld(ultra_timing_setting.turnaround_cycles
						+ ultra_timing_setting.crc_setup_extra_cycles);
				end
			end
			dma_timing_pkg::S_U_MLI: begin
				if (expired) begin
					d.st = dma_timing_pkg::S_U_CRC;
					d.pins.crc_valid = 1'b1;
					d.cnt = ld(ultra_timing_setting.data_valid_setup_cycles);
				end
			end
			dma_timing_pkg::S_U_CRC: begin
				if (expired) begin
					d.st = dma_timing_pkg::S_U_POST;
					d.pins.dma_acknowledge = 1'b0;
					d.cnt = ld(ultra_timing_setting.ack_timing_cycles);
				end
			end
			dma_timing_pkg::S_U_POST: begin
				if (expired) begin
					d.st = dma_timing_pkg::S_IDLE;
					d.pins.crc_valid = 1'b0;
					d.pins.write_strobe = 1'b0;
					d.pins.host_drive = 1'b0;
				end
			end
			default: begin
				d.st = dma_timing_pkg::S_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pins = q.pins;
	assign busy = (q.st != dma_timing_pkg::S_IDLE);

	// Strobe must not rise while acknowledge is still in setup.
	property p_setup;
		@(posedge ref_clk) disable iff (rst)
		$rose(q.st == dma_timing_pkg::S_M_SETUP) |-> !pins.read_strobe && !pins.write_strobe;
	endproperty
	ack_before_strobe_a: assert property (p_setup) else $error("strobe during ack setup");

	mdma_cs_ack_a: assert property (@(posedge ref_clk) disable iff (rst)
		(q.st inside {dma_timing_pkg::S_M_SETUP, dma_timing_pkg::S_M_ACTIVE})
		|-> pins.dma_acknowledge && pins.drive_chip_selects)
		else $error("ack or chip select dropped mid burst");

	strobe_width_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(pins.read_strobe) && multiword_timing_setting.strobe_active_cycles == 8'h02
		&& $stable(multiword_timing_setting)
		|-> pins.read_strobe ##1 pins.read_strobe ##1 !pins.read_strobe)
		else $error("read strobe width wrong");

	ack_trail_a: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(pins.dma_acknowledge) && !ultra_mode |-> !pins.read_strobe && !pins.write_strobe)
		else $error("ack fell with strobe active");

	crc_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(pins.dma_acknowledge) && q.st == dma_timing_pkg::S_U_POST |-> pins.crc_valid)
		else $error("crc not held after ack");

	crc_setup_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(pins.crc_valid) |-> pins.dma_acknowledge)
		else $error("crc valid without ack");

	turn_release_a: assert property (@(posedge ref_clk) disable iff (rst)
		q.st == dma_timing_pkg::S_U_TURN |-> !pins.host_drive)
		else $error("host drove during turnaround");

	mli_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
		q.st == dma_timing_pkg::S_U_MLI |-> pins.host_drive && !pins.crc_valid)
		else $error("interlock state wrong");

	ultra_pre_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		q.st == dma_timing_pkg::S_U_PRE
		|-> !pins.dma_acknowledge && !pins.read_strobe && !pins.write_strobe)
		else $error("lines moved before ultra acknowledge");

endmodule

// File: src/dma_timing_pkg.sv
// Shared types and constants for the ATA DMA strobe timing generator.
package dma_timing_pkg;

	localparam int CW = 8;
	localparam logic [CW-1:0] ONE = 8'h01;
	localparam logic [CW-1:0] ZERO = 8'h00;
	// Fixed part of the data-in turnaround wait, in cycles.
	localparam logic [CW-1:0] TURN_FIXED = 8'h02;
	localparam logic [CW-1:0] TURN_EXTRA = 8'h01;

	typedef struct packed {
		logic [CW-1:0] strobe_active_cycles;
		logic [CW-1:0] strobe_negated_cycles;
		logic [CW-1:0] read_recovery_cycles;
		logic [CW-1:0] write_recovery_cycles;
		logic [CW-1:0] ack_setup_cycles;
		logic [CW-1:0] mdma_end_cycle_extra;
	} multiword_timing_setting_t;

	typedef struct packed {
		logic [CW-1:0] turnaround_cycles;
		logic [CW-1:0] crc_setup_extra_cycles;
		logic [CW-1:0] data_valid_setup_cycles;
		logic [CW-1:0] ack_timing_cycles;
		logic [CW-1:0] envelope_cycles;
		logic [CW-1:0] ready_pause_cycles;
	} ultra_timing_setting_t;

	typedef struct packed {
		logic read_strobe;
		logic write_strobe;
		logic dma_acknowledge;
		logic drive_chip_selects;
		logic crc_valid;
		logic host_drive;
	} ata_pins_t;

	typedef enum logic [3:0] {
		S_IDLE, S_M_SETUP, S_M_ACTIVE, S_M_RECOVER, S_M_END,
		S_U_PRE, S_U_ENV, S_U_BURST, S_U_TURN, S_U_MLI, S_U_CRC, S_U_POST
	} state_t;

endpackage

// File: test/drive_model.sv
// Behavioural drive that raises DMA requests and releases the data bus.
`timescale 1ns/1ps
module drive_model (
	// Clock and control.
	input wire logic ref_clk,
	input wire logic want,
	input wire logic [2:0] lag,
	// Drive pins.
	output logic dma_request,
	output logic device_bus_released
);
	logic [2:0] n = 3'h0;
	initial dma_request = 1'b0;
	initial device_bus_released = 1'b0;
	// A slow drive answers a change of want only after lag extra cycles.
	always @(posedge ref_clk) begin
		n <= (want != dma_request) ? n + 3'h1 : 3'h0;
		if (want != dma_request && n >= lag) dma_request <= want;
		device_bus_released <= !dma_request;
	end
endmodule

// File: test/ata_dma_strobe_timing_bench.sv
// Self-checking bench for the DMA strobe timing generator.
`timescale 1ns/1ps
module ata_dma_strobe_timing_bench;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic ultra_mode = 1'b0;
	logic write_dir = 1'b0;
	logic [7:0] word_count = 8'h00;
	logic stop = 1'b0;
	logic want = 1'b0;
	logic [2:0] lag = 3'h0;
	dma_timing_pkg::multiword_timing_setting_t m = '0;
	dma_timing_pkg::ultra_timing_setting_t u = '0;
	dma_timing_pkg::ata_pins_t pins;
	dma_timing_pkg::ata_pins_t prev = '0;
	logic dma_request;
	logic device_bus_released;
	logic busy;
	logic [7:0] expq[$];
	logic [7:0] cnt = 8'h00;
	int err_count = 0;
	int tests_run = 0;
	always #12.5 ref_clk = ~ref_clk;
	ata_dma_strobe_timing u_dut (.ref_clk(ref_clk), .rst(rst), .start(start),
		.ultra_mode(ultra_mode), .write_dir(write_dir), .word_count(word_count), .stop(stop),
		.multiword_timing_setting(m), .ultra_timing_setting(u), .dma_request(dma_request),
		.device_bus_released(device_bus_released), .pins(pins), .busy(busy));
	drive_model u_drv (.ref_clk(ref_clk), .want(want), .lag(lag), .dma_request(dma_request),
		.device_bus_released(device_bus_released));
	function automatic logic [7:0] eff(input logic [7:0] v);
		return (v == 8'h00) ? 8'h01 : v;
	endfunction
	task automatic print_verdict;
		$display("tests_run %0d err_count %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic step;
		@(posedge ref_clk);
		#2;
	endtask
	// Waits for busy (sel 0) or the Ultra handshake line (sel 1) to reach v.
	task automatic wait_for(input int sel, input logic v);
		int i;
		for (i = 0; i < 3000 && (sel ? pins.write_strobe : busy) !== v; i++) @(negedge ref_clk);
		if ((sel ? pins.write_strobe : busy) !== v) begin
			$display("unexpected hang expected %0d seen %0d", v, !v);
			err_count++;
			print_verdict();
		end
	endtask
	// Every strobe or CRC edge and every acknowledge fall closes one interval; an acknowledge rise starts one.
	always @(negedge ref_clk) begin
		logic [7:0] want_cnt;
		cnt = cnt + 8'h01;
		if (!rst && !ultra_mode && pins.drive_chip_selects !== pins.dma_acknowledge) begin
			$display("unexpected chip_selects expected %0d seen %0d", pins.dma_acknowledge,
				pins.drive_chip_selects);
			err_count++;
		end
		if (rst || (pins.dma_acknowledge && !prev.dma_acknowledge) ||
			(ultra_mode && pins.host_drive && !prev.host_drive)) begin
			cnt = 8'h00;
		end else if ({pins.read_strobe, pins.write_strobe, pins.dma_acknowledge, pins.crc_valid}
			!== {prev.read_strobe, prev.write_strobe, prev.dma_acknowledge, prev.crc_valid}) begin
			tests_run++;
			want_cnt = (expq.size() != 0) ? expq.pop_front() : 8'hff;
			if (want_cnt !== cnt) begin
				$display("unexpected interval expected %0d seen %0d", want_cnt, cnt);
				err_count++;
			end
			cnt = 8'h00;
		end
		prev = pins;
	end
	initial begin
		void'($urandom(80961));
		repeat (20) @(posedge ref_clk);
		#2 rst = 1'b0;
		for (int t = 0; t < 6; t++) begin
			for (int k = 0; k < 6; k++) begin
				m[k*8 +: 8] = 8'($urandom_range(0, 5));
				u[k*8 +: 8] = 8'($urandom_range(0, 5));
			end
			// The first read burst uses a two-cycle strobe so the width assertion fires.
			if (t == 0) m.strobe_active_cycles = 8'h02;
			lag = 3'($urandom_range(0, 3));
			ultra_mode = (t % 3 == 2);
			write_dir = (t % 3 == 1);
			word_count = 8'(t);
			if (ultra_mode) begin
				expq.push_back(eff(u.envelope_cycles));
				expq.push_back(eff(8'(u.turnaround_cycles + u.crc_setup_extra_cycles)));
				expq.push_back(eff(u.data_valid_setup_cycles));
				expq.push_back(eff(u.ack_timing_cycles));
			end else begin
				expq.push_back(eff(m.ack_setup_cycles));
				for (int w = 0; w < ((t < 2) ? 1 : t); w++) begin
					if (w > 0) expq.push_back(write_dir ? eff(m.write_recovery_cycles) :
						eff(m.read_recovery_cycles));
					expq.push_back(eff(m.strobe_active_cycles));
				end
				expq.push_back(eff(8'(m.strobe_negated_cycles + m.mdma_end_cycle_extra)));
			end
			want = 1'b1;
			start = 1'b1;
			wait_for(0, 1'b1);
			step();
			start = 1'b0;
			if (ultra_mode) begin
				wait_for(1, 1'b1);
				step();
				stop = 1'b1;
				want = 1'b0;
			end
			wait_for(0, 1'b0);
			step();
			stop = 1'b0;
			want = 1'b0;
			repeat (8) step();
			$display("test %0d done, errors so far %0d", t, err_count);
		end
		if (expq.size() != 0) begin
			$display("unexpected pending expected %0d seen %0d", 0, expq.size());
			err_count++;
		end
		print_verdict();
	end
endmodule
